//--- src/cellmon_pkg.sv
// Purpose: Constants shared by the cell monitor register bank.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Result slots are kept in one flat table.
package cellmon_pkg;
  localparam logic [11:0] OFS_THRESH = 12'h000;
  localparam logic [11:0] OFS_TIMER = 12'h004;
  localparam logic [11:0] OFS_DISCH = 12'h008;
  localparam logic [11:0] OFS_CLEAR = 12'h00C;
  localparam logic [11:0] OFS_RESULT = 12'h100;
  localparam int UV_LSB = 0;
  localparam int OV_LSB = 16;
  localparam int CODE_W = 12;
  localparam int MON_EN_BIT = 0;
  localparam int RANGE_BIT = 1;
  localparam int TMO_LSB = 8;
  localparam int TMO_W = 6;
  localparam int CLR_CELL_BIT = 0;
  localparam int CLR_FILT_BIT = 1;
  localparam int CLR_SPIN_BIT = 2;
  localparam int CLR_AUX_BIT = 3;
  localparam logic [11:0] UV_RESET = 12'h800;
  localparam logic [11:0] OV_RESET = 12'h7FF;
  localparam logic [15:0] RES_RESET = 16'h8000;
  localparam logic [15:0] TEMP_RESET = 16'h7FFF;
  localparam logic [6:0] IDX_CELL = 7'h00;
  localparam logic [6:0] IDX_AVG = 7'h10;
  localparam logic [6:0] IDX_FILT = 7'h20;
  localparam logic [6:0] IDX_SPIN = 7'h30;
  localparam logic [6:0] IDX_GPIO = 7'h40;
  localparam logic [6:0] IDX_RGPIO = 7'h4A;
  localparam logic [6:0] IDX_STACK = 7'h54;
  localparam logic [6:0] IDX_BOTTOM = 7'h55;
  localparam logic [6:0] IDX_REF2 = 7'h56;
  localparam logic [6:0] IDX_TEMP = 7'h57;
  localparam int NUM_RES = 88;
  localparam int CLK_HZ = 10_000_000;
  localparam int MINUTE_S = 60;
  localparam int MINUTE_CYCLES = MINUTE_S * CLK_HZ;
  localparam logic [3:0] LONG_STEP_MIN = 4'hF;
  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_RUN = 2'b01,
    TMR_DONE = 2'b11
  } tmr_state_type;
endpackage : cellmon_pkg

//--- src/cellmon_regs.sv
// Purpose: Threshold, balancing and result register bank on APB.
// Assumes: Conversion logic writes results through the RES_* port.
// Notes: Results are read-only from the bus side.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (R1) Undervoltage code, 12 bits, resets to 0x800, software writable.
// (R2) Overvoltage code, 12 bits, resets to 0x7FF, software writable.
// (R3) Timer monitor runs in extended balancing only when enabled.
// (R4) Range bit picks 16-minute or 1-minute steps; reset picks 1-minute.
// (R5) Writing timeout loads countdown; reading gives remaining steps.
// (R6) Reads 1 with one step or less left, 0 when expired.
// (R7) Each discharge bit holds its cell switch on or off.
// (R8) Cell results reset to 0x8000 at power-up and cell clear.
// (R9) Averaged results reset to 0x8000 at power-up and cell clear.
// (R10) Filtered results reset to 0x8000 at power-up and filter clear.
// (R11) S-pin results reset to 0x8000 at power-up and S-pin clear.
// (R12) Ten primary and ten redundant GPIO results, reset 0x8000.
// (R13) Stack result resets to 0x8000 on power-up, sleep, aux clear.
// (R14) Bottom input result resets to 0x8000 likewise.
// (R15) Second reference result resets to 0x8000 likewise.
// (R16) Temperature: 0x7FFF on power-up or sleep, 0x8000 on aux clear.
// (R17) Results ignore bus writes; only conversions, clears and sleep change them.
module cellmon_regs
  import cellmon_pkg::*;
#(
  parameter int unsigned MINUTE_TICKS = MINUTE_CYCLES,
  parameter int CELLS = 16
) (
  input wire logic MCLK_IN,
  input wire logic NRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic SLEEP_IN,
  input wire logic EXT_BAL_IN,
  input wire logic RES_WE_IN,
  input wire logic [6:0] RES_IDX_IN,
  input wire logic [15:0] RES_DATA_IN,
  output logic [CODE_W-1:0] UV_CODE_OUT,
  output logic [CODE_W-1:0] OV_CODE_OUT,
  output logic [CELLS-1:0] CELL_SWITCH_OUT,
  output logic TIMER_RUN_OUT,
  output logic TIMEOUT_OUT
);

  logic [CODE_W-1:0] undervoltage_threshold_code_q;
  logic [CODE_W-1:0] overvoltage_threshold_code_q;
  logic discharge_timer_monitor_enable_q;
  logic discharge_timer_range_q;
  logic [TMO_W-1:0] discharge_timeout_count_q;
  logic [CELLS-1:0] cell_discharge_switch_q;
  logic [15:0] result_q [NUM_RES];
  logic [31:0] prescale_q;
  logic [3:0] step_q;
  tmr_state_type tmr_state_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic setup;
  logic wr_en;
  logic [3:0] clr_cmd;
  logic minute_tick;
  logic step_done;
  logic mapped;
  logic [6:0] rd_idx;
  logic [16:0] clear_dec [NUM_RES];

  // Slot index from a byte address inside the result window
  function automatic logic [6:0] slot_of(input logic [11:0] addr);
    logic [11:0] rel;
    rel = addr - OFS_RESULT;
    return rel[8:2];
  endfunction : slot_of

  // Clear decision for one slot: {hit, value}
  function automatic logic [16:0] clear_of(input logic [6:0] idx,
                                           input logic [3:0] cmd,
                                           input logic slp);
    logic [16:0] r;
    r = {1'b0, RES_RESET};
    if (idx < IDX_FILT) begin
      r[16] = cmd[CLR_CELL_BIT];
    end else if (idx < IDX_SPIN) begin
      r[16] = cmd[CLR_FILT_BIT];
    end else if (idx < IDX_GPIO) begin
      r[16] = cmd[CLR_SPIN_BIT];
    end else if (idx < IDX_STACK) begin
      r[16] = cmd[CLR_AUX_BIT];
    end else if (slp) begin
      r = {1'b1, (idx == IDX_TEMP) ? TEMP_RESET : RES_RESET};
    end else begin
      r[16] = cmd[CLR_AUX_BIT];
    end
    return r;
  endfunction : clear_of

  assign setup = PSEL_IN & ~PENABLE_IN;
  // Writes land only at the completing access edge
  assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN & pready_q;
  assign clr_cmd = (wr_en && PADDR_IN == OFS_CLEAR) ?
                   PWDATA_IN[3:0] : 4'h0;
  assign rd_idx = slot_of(PADDR_IN);
  // Full offset is bounded, so high addresses cannot alias onto slots
  assign mapped = (PADDR_IN[1:0] == 2'b00) &&
                  (PADDR_IN <= OFS_CLEAR ||
                   (PADDR_IN >= OFS_RESULT &&
                    PADDR_IN - OFS_RESULT < 12'(4 * NUM_RES)));

  // No wait state: answer is prepared during setup
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= setup & ~mapped;
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !PWRITE_IN) begin
      prdata_q <= 32'h0000_0000;
      case (PADDR_IN)
        OFS_THRESH: begin
          prdata_q[UV_LSB +: CODE_W] <= undervoltage_threshold_code_q;
          prdata_q[OV_LSB +: CODE_W] <= overvoltage_threshold_code_q;
        end
        OFS_TIMER: begin
          prdata_q[MON_EN_BIT] <= discharge_timer_monitor_enable_q;
          prdata_q[RANGE_BIT] <= discharge_timer_range_q;
          prdata_q[TMO_LSB +: TMO_W] <= discharge_timeout_count_q; // R5 R6
        end
        OFS_DISCH: begin
          prdata_q[CELLS-1:0] <= cell_discharge_switch_q;
        end
        default: begin
          if (mapped && PADDR_IN >= OFS_RESULT) begin
            prdata_q[15:0] <= result_q[rd_idx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      undervoltage_threshold_code_q <= UV_RESET; // R1
      overvoltage_threshold_code_q <= OV_RESET; // R2
    end else if (wr_en && PADDR_IN == OFS_THRESH) begin
      undervoltage_threshold_code_q <= PWDATA_IN[UV_LSB +: CODE_W]; // R1
      overvoltage_threshold_code_q <= PWDATA_IN[OV_LSB +: CODE_W]; // R2
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      discharge_timer_monitor_enable_q <= 1'b0; // R3
      discharge_timer_range_q <= 1'b0; // R4
    end else if (wr_en && PADDR_IN == OFS_TIMER) begin
      discharge_timer_monitor_enable_q <= PWDATA_IN[MON_EN_BIT]; // R3
      discharge_timer_range_q <= PWDATA_IN[RANGE_BIT]; // R4
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cell_discharge_switch_q <= '0; // R7
    end else if (wr_en && PADDR_IN == OFS_DISCH) begin
      cell_discharge_switch_q <= PWDATA_IN[CELLS-1:0]; // R7
    end
  end

  // Minute prescaler; a fresh load restarts the partial step
  assign minute_tick = (prescale_q == MINUTE_TICKS - 1);
  assign step_done = minute_tick &&
    (!discharge_timer_range_q || step_q == LONG_STEP_MIN); // R4

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      prescale_q <= 32'h0000_0000;
      step_q <= 4'h0;
    end else if (tmr_state_q != TMR_RUN ||
                 (wr_en && PADDR_IN == OFS_TIMER)) begin
      prescale_q <= 32'h0000_0000;
      step_q <= 4'h0;
    end else if (minute_tick) begin
      prescale_q <= 32'h0000_0000;
      step_q <= step_done ? 4'h0 : step_q + 4'h1;
    end else begin
      prescale_q <= prescale_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      discharge_timeout_count_q <= '0;
    end else if (wr_en && PADDR_IN == OFS_TIMER) begin
      discharge_timeout_count_q <= PWDATA_IN[TMO_LSB +: TMO_W]; // R5
    end else if (tmr_state_q == TMR_RUN && step_done &&
                 discharge_timeout_count_q != '0) begin
      // Count 1 covers the last partial step
      discharge_timeout_count_q <= discharge_timeout_count_q - 1'b1; // R6
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tmr_state_q <= TMR_IDLE;
    end else begin
      case (tmr_state_q)
        TMR_IDLE: begin
          if (discharge_timer_monitor_enable_q && EXT_BAL_IN &&
              discharge_timeout_count_q != '0) begin
            tmr_state_q <= TMR_RUN; // R3
          end
        end
        TMR_RUN: begin
          if (!discharge_timer_monitor_enable_q || !EXT_BAL_IN) begin
            tmr_state_q <= TMR_IDLE; // R3
          end else if (discharge_timeout_count_q == '0) begin
            tmr_state_q <= TMR_DONE;
          end
        end
        TMR_DONE: begin
          if (wr_en && PADDR_IN == OFS_TIMER) begin
            tmr_state_q <= TMR_IDLE;
          end
        end
        default: begin
          tmr_state_q <= TMR_IDLE;
        end
      endcase
    end
  end

  // Per-slot clear decision, {hit, value}
  always_comb begin
    for (int i = 0; i < NUM_RES; i++) begin
      clear_dec[i] = clear_of(7'(i), clr_cmd, SLEEP_IN);
    end
  end

  // Outside sleep, conversion data beats a clear aimed at the same slot
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      for (int i = 0; i < NUM_RES; i++) begin
        result_q[i] <= (i == int'(IDX_TEMP)) ? TEMP_RESET : RES_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_RES; i++) begin
        if (RES_WE_IN && RES_IDX_IN == 7'(i) && !SLEEP_IN) begin
          result_q[i] <= RES_DATA_IN; // R17
        end else if (clear_dec[i][16]) begin
          // R8 R9 R10 R11 R12 R13 R14 R15 R16
          result_q[i] <= clear_dec[i][15:0];
        end
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      UV_CODE_OUT <= UV_RESET;
      OV_CODE_OUT <= OV_RESET;
      CELL_SWITCH_OUT <= '0;
      TIMER_RUN_OUT <= 1'b0;
      TIMEOUT_OUT <= 1'b0;
    end else begin
      UV_CODE_OUT <= undervoltage_threshold_code_q;
      OV_CODE_OUT <= overvoltage_threshold_code_q;
      CELL_SWITCH_OUT <= cell_discharge_switch_q; // R7
      TIMER_RUN_OUT <= (tmr_state_q == TMR_RUN);
      TIMEOUT_OUT <= (tmr_state_q == TMR_DONE);
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  sequence thresh_write_s;
    wr_en && PADDR_IN == OFS_THRESH;
  endsequence

  sequence apb_setup_s;
    PSEL_IN && !PENABLE_IN;
  endsequence

  apb_ready_a: assert property (apb_setup_s ##1 PSEL_IN && PENABLE_IN
      |-> PREADY_OUT)
    else $error("access phase not answered");

  uv_write_a: assert property (thresh_write_s |=> ##1 // R1
      UV_CODE_OUT == $past(PWDATA_IN[11:0], 2))
    else $error("undervoltage code not loaded");

  ov_write_a: assert property (thresh_write_s |=> ##1 // R2
      OV_CODE_OUT == $past(PWDATA_IN[27:16], 2))
    else $error("overvoltage code not on output");

  monitor_gate_a: assert property ( // R3
      !discharge_timer_monitor_enable_q |=> tmr_state_q != TMR_RUN)
    else $error("timer runs while disabled");

  short_step_a: assert property ( // R4
      tmr_state_q == TMR_RUN && !discharge_timer_range_q && minute_tick
      && discharge_timeout_count_q != '0 && !wr_en
      |=> discharge_timeout_count_q ==
          $past(discharge_timeout_count_q) - 1'b1)
    else $error("one-minute step not counted");

  count_read_a: assert property (apb_setup_s ##0 (!PWRITE_IN && // R5
      PADDR_IN == OFS_TIMER) |=>
      PRDATA_OUT[13:8] == $past(discharge_timeout_count_q))
    else $error("remaining count not returned");

  count_hold_a: assert property (!step_done && !wr_en // R6
      |=> $stable(discharge_timeout_count_q))
    else $error("count moved without a step");

  switch_follow_a: assert property (wr_en && // R7
      PADDR_IN == OFS_DISCH |=> ##1 CELL_SWITCH_OUT ==
      $past(PWDATA_IN[15:0], 2))
    else $error("discharge switch not applied");

  cell_clear_a: assert property (clr_cmd[CLR_CELL_BIT] && !RES_WE_IN // R8
      |=> result_q[0] == RES_RESET && result_q[16] == RES_RESET)
    else $error("cell results not cleared");

  filt_clear_a: assert property (clr_cmd[CLR_FILT_BIT] && !RES_WE_IN // R10
      |=> result_q[32] == RES_RESET)
    else $error("filtered result not cleared");

  temp_sleep_a: assert property (SLEEP_IN |=> // R16
      result_q[87] == TEMP_RESET && result_q[84] == RES_RESET)
    else $error("sleep reset values wrong");

  temp_aux_a: assert property (clr_cmd[CLR_AUX_BIT] && !SLEEP_IN // R16
      && !RES_WE_IN |=> result_q[87] == RES_RESET)
    else $error("aux clear of temperature wrong");

  result_ro_a: assert property (wr_en && mapped // R17
      && PADDR_IN >= OFS_RESULT && !RES_WE_IN && !SLEEP_IN |=>
      result_q[$past(rd_idx)] == $past(result_q[rd_idx]))
    else $error("bus write changed a result");

  spin_clear_a: assert property (clr_cmd[CLR_SPIN_BIT] && !RES_WE_IN // R11
      |=> result_q[48] == RES_RESET && result_q[63] == RES_RESET)
    else $error("S-pin results not cleared");

  gpio_clear_a: assert property (clr_cmd[CLR_AUX_BIT] && !RES_WE_IN // R12
      |=> result_q[64] == RES_RESET && result_q[83] == RES_RESET)
    else $error("GPIO results not cleared");

  sleep_refs_a: assert property (SLEEP_IN |=> // R14 R15
      result_q[85] == RES_RESET && result_q[86] == RES_RESET)
    else $error("sleep left bottom or reference result");

endmodule : cellmon_regs

`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench for the cell monitor register bank.
// Assumes: APB slave may insert wait states; short minute.
// Notes: Result slots are loaded through the conversion write port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e), `__LINE__)
module testbench;
  import cellmon_pkg::*;
  localparam int TICKS = 8;
  logic clk, nrst, psel, penable, pwrite, sleep, ext_bal, res_we;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, run, tout;
  logic [6:0] res_idx;
  logic [15:0] res_data, sw;
  logic [11:0] uv, ov;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;

  cellmon_regs #(.MINUTE_TICKS(TICKS), .CELLS(16)) i_dut (
    .MCLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .SLEEP_IN(sleep), .EXT_BAL_IN(ext_bal), .RES_WE_IN(res_we),
    .RES_IDX_IN(res_idx), .RES_DATA_IN(res_data), .UV_CODE_OUT(uv),
    .OV_CODE_OUT(ov), .CELL_SWITCH_OUT(sw), .TIMER_RUN_OUT(run),
    .TIMEOUT_OUT(tout));

  task automatic conclude;
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input int line);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: line %0d got %h want %h", $time, line,
               got, exp);
    end
  endtask : check

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  task automatic load(input logic [6:0] s, input logic [15:0] d);
    res_we <= 1'b1;
    res_idx <= s;
    res_data <= d;
    @(posedge clk);
    res_we <= 1'b0;
    @(posedge clk);
  endtask : load

  function automatic logic [11:0] sa(input logic [6:0] s);
    return OFS_RESULT + {3'b0, s, 2'b00};
  endfunction : sa

  function automatic int grp(input logic [6:0] s);
    return s < IDX_FILT ? 0 : s < IDX_SPIN ? 1 : s < IDX_GPIO ? 2 : 3;
  endfunction : grp

  task automatic t_reset;
    logic [31:0] r;
    logic e;
    `CHK(uv, UV_RESET);
    `CHK(ov, OV_RESET);
    `CHK(sw, 16'h0);
    rd(OFS_THRESH, r);
    `CHK(r, 32'h07FF0800);
    rd(OFS_TIMER, r);
    `CHK(r, 32'h0);
    rd(sa(IDX_CELL), r);
    `CHK(r, RES_RESET);
    rd(sa(IDX_TEMP), r);
    `CHK(r, TEMP_RESET);
    apb(1'b0, 12'h260, 32'h0, r, e);
    `CHK(e, 1'b1);
  endtask : t_reset

  task automatic t_regs;
    logic [31:0] r;
    wr(OFS_THRESH, 32'h0ABC0123);
    @(posedge clk);
    `CHK(uv, 12'h123);
    `CHK(ov, 12'hABC);
    rd(OFS_THRESH, r);
    `CHK(r, 32'h0ABC0123);
    wr(OFS_DISCH, 32'h8001);
    @(posedge clk);
    `CHK(sw, 16'h8001);
    rd(OFS_DISCH, r);
    `CHK(r, 32'h8001);
    wr(OFS_DISCH, 32'h0);
    @(posedge clk);
    `CHK(sw, 16'h0);
    load(7'd5, 16'h1234);
    wr(sa(7'd5), 32'hFFFF);
    rd(sa(7'd5), r);
    `CHK(r, 32'h1234);
  endtask : t_regs

  // Each clear must hit its own group and spare all the others
  task automatic t_clear;
    logic [6:0] s[10] = '{7'd0, 7'd16, 7'd32, 7'd48, 7'd64, 7'd74,
                          7'd84, 7'd85, 7'd86, 7'd87};
    logic [31:0] r;
    for (int b = 0; b < 4; b++) begin
      foreach (s[i]) load(s[i], 16'h0100 + 16'(i));
      wr(OFS_CLEAR, 32'h1 << b);
      foreach (s[i]) begin
        rd(sa(s[i]), r);
        `CHK(r, grp(s[i]) == b ? 32'h8000 : 32'h0100 + i);
      end
    end
  endtask : t_clear

  task automatic t_sleep;
    logic [31:0] r;
    load(IDX_STACK, 16'h0111);
    load(IDX_TEMP, 16'h0222);
    load(IDX_GPIO, 16'h0333);
    load(IDX_BOTTOM, 16'h0555);
    sleep <= 1'b1;
    @(posedge clk);
    load(IDX_REF2, 16'h0444);
    rd(sa(IDX_STACK), r);
    `CHK(r, 32'h8000);
    rd(sa(IDX_BOTTOM), r);
    `CHK(r, 32'h8000);
    rd(sa(IDX_REF2), r);
    `CHK(r, 32'h8000);
    rd(sa(IDX_TEMP), r);
    `CHK(r, 32'h7FFF);
    rd(sa(IDX_GPIO), r);
    `CHK(r, 32'h0333);
    sleep <= 1'b0;
    @(posedge clk);
  endtask : t_sleep

  // Expiry is watched with a margin after the exact step count, and before it too for 16-minute steps
  task automatic t_timer;
    logic [31:0] r;
    int n;
    wr(OFS_TIMER, 32'h0201);
    repeat (3 * TICKS) @(posedge clk);
    `CHK(run, 1'b0);
    wr(OFS_TIMER, 32'h0200);
    ext_bal <= 1'b1;
    repeat (3 * TICKS) @(posedge clk);
    `CHK(run, 1'b0);
    rd(OFS_TIMER, r);
    `CHK(r[13:8], 6'd2);
    wr(OFS_TIMER, 32'h0201);
    repeat (3) @(posedge clk);
    `CHK(run, 1'b1);
    repeat (TICKS - 1) @(posedge clk);
    rd(OFS_TIMER, r);
    `CHK(r[13:8], 6'd1);
    n = 0;
    while (tout !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    `CHK(tout, 1'b1);
    rd(OFS_TIMER, r);
    `CHK(r[13:8], 6'd0);
    wr(OFS_TIMER, 32'h0103);
    repeat (16 * TICKS - 2) @(posedge clk);
    `CHK(tout, 1'b0);
    n = 0;
    while (tout !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    `CHK(tout, 1'b1);
    ext_bal <= 1'b0;
  endtask : t_timer

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sleep = 1'b0;
    ext_bal = 1'b0;
    res_we = 1'b0;
    res_idx = 7'h00;
    res_data = 16'h0000;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_clear();
    t_sleep();
    t_timer();
    conclude();
  end
endmodule : testbench
`default_nettype wire
